// ---- verilog/lbe_regs.svh ----
// register offsets, field positions, reset values and cycle counts
`ifndef LBE_REGS_SVH
`define LBE_REGS_SVH

// ==========================================================================
// register map (byte offsets, address bits 11:2 decoded)
`define LBE_OFF_CMD      12'h000
`define LBE_OFF_INSTR    12'h004
`define LBE_OFF_PC       12'h008
`define LBE_OFF_FLAGS    12'h00C
`define LBE_OFF_STATUS   12'h010
`define LBE_OFF_SP       12'h014
`define LBE_OFF_RF_BASE  12'h100
`define LBE_OFF_RF_LAST  12'h13C
`define LBE_RF_DEPTH     16

// ==========================================================================
// flags register fields
`define LBE_FLG_C        7
`define LBE_FLG_N        6
`define LBE_FLG_Z        5
`define LBE_FLG_V        4
`define LBE_FLG_IEL      3
`define LBE_FLG_IEH      2
`define LBE_FLAGS_RST    8'h00
`define LBE_ENALL_VALUE  8'h0C
`define LBE_IEH_MASK     8'h04
`define LBE_IEL_MASK     8'h08

// ==========================================================================
// status fields
`define LBE_STS_BUSY     0
`define LBE_STS_BAD      1

// ==========================================================================
// opcodes
`define LBE_OP_DECJ_A    8'hBA
`define LBE_OP_DECJ_B    8'hCA
`define LBE_OP_DSUB_BA   8'h6F
`define LBE_OP_DSUB_RA   8'h1F
`define LBE_OP_DSUB_RB   8'h3F
`define LBE_OP_DSUB_RR   8'h4F
`define LBE_OP_DSUB_IA   8'h2F
`define LBE_OP_DSUB_IB   8'h5F
`define LBE_OP_DSUB_IR   8'h7F
`define LBE_OP_EXT       8'hF0
`define LBE_OP_ENALL2    8'h0C

// ==========================================================================
// execution cycle counts
`define LBE_CYC_DECJ     4'd10
`define LBE_CYC_DSUB_BA  4'd10
`define LBE_CYC_DSUB_RA  4'd9
`define LBE_CYC_DSUB_RB  4'd9
`define LBE_CYC_DSUB_RR  4'd11
`define LBE_CYC_DSUB_IA  4'd8
`define LBE_CYC_DSUB_IB  4'd8
`define LBE_CYC_DSUB_IR  4'd10
`define LBE_CYC_ENALL    4'd6

`endif

// ---- verilog/lbe_pkg.sv ----
// types shared by the execution block
package lbe_pkg;

    typedef enum logic [2:0] {
        ph_idle,
        ph_exec,
        ph_irq_push,
        ph_irq_mask,
        ph_pop
    } lbe_state_e;

    typedef enum logic [1:0] {
        cmd_exec,
        cmd_irq_entry,
        cmd_return,
        cmd_pop_flags
    } lbe_cmd_e;

    typedef enum logic [1:0] {
        k_bad,
        k_decj,
        k_dsub,
        k_enall
    } lbe_kind_e;

endpackage

// ---- verilog/lbe_bcd_sub.sv ----
// packed bcd subtract with no-borrow carry
`timescale 1ns/100ps
`default_nettype none
module lbe_bcd_sub
    import lbe_pkg::*;
(
    input  wire logic [7:0] dst,
    input  wire logic [7:0] src,
    input  wire logic       carry_in,
    output logic      [7:0] result,
    output logic            carry_out
);
    logic [4:0] lo;
    logic [4:0] hi;
    logic [3:0] lo_adj;
    logic [3:0] hi_adj;

    // carry in is a no-borrow bit, so borrow-in is its inverse
    always_comb begin
        lo     = {1'b0, dst[3:0]} - {1'b0, src[3:0]} - {4'h0, ~carry_in};
        lo_adj = lo[4] ? lo[3:0] - 4'h6 : lo[3:0];
        hi     = {1'b0, dst[7:4]} - {1'b0, src[7:4]} - {4'h0, lo[4]};
        hi_adj = hi[4] ? hi[3:0] - 4'h6 : hi[3:0];
        result    = {hi_adj, lo_adj};
        carry_out = ~hi[4];
    end
endmodule // lbe_bcd_sub
`default_nettype wire

// ---- verilog/lbe_exec.sv ----
// ahb-lite execution unit for loop, decimal subtract and enable-all ops
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "lbe_regs.svh"
module lbe_exec
    import lbe_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             high_level_irq_enable,
    output logic             low_level_irq_enable
);
    // ======================================================================
    // state
    lbe_state_e  state_ff;
    logic [3:0]  cnt_ff;
    logic [31:0] instr_ff;
    logic [15:0] pc_ff;
    logic [7:0]  flags_ff;
    logic [7:0]  sp_ff;
    logic        bad_ff;
    logic [7:0]  rf_ff [`LBE_RF_DEPTH];
    logic        wr_pend_ff;
    logic [11:0] wr_addr_ff;
    logic [31:0] hrdata_ff;

    logic        addr_ok;
    logic        wr_go;
    logic        idle;
    logic        commit;
    lbe_kind_e   kind;
    logic [3:0]  cycles;
    logic [3:0]  d_idx;
    logic [7:0]  d_val;
    logic [7:0]  s_val;
    logic [7:0]  dj_val;
    logic [7:0]  bcd_res;
    logic        bcd_c;
    logic        rf_we;
    logic [3:0]  rf_wa;
    logic [7:0]  rf_wd;
    logic [3:0]  sp_up;

    // ======================================================================
    // decode
    function automatic lbe_kind_e kind_of(input logic [7:0] op0,
                                          input logic [7:0] op1);
        if (op0 == `LBE_OP_DECJ_A || op0 == `LBE_OP_DECJ_B) begin
            return k_decj;
        end else if (op0 == `LBE_OP_DSUB_BA || op0 == `LBE_OP_DSUB_RA ||
                     op0 == `LBE_OP_DSUB_RB || op0 == `LBE_OP_DSUB_RR ||
                     op0 == `LBE_OP_DSUB_IA || op0 == `LBE_OP_DSUB_IB ||
                     op0 == `LBE_OP_DSUB_IR) begin
            return k_dsub;
        end else if (op0 == `LBE_OP_EXT && op1 == `LBE_OP_ENALL2) begin
            return k_enall;
        end else begin
            return k_bad;
        end
    endfunction

    function automatic logic [3:0] cycles_of(input logic [7:0] op0);
        case (op0)
            `LBE_OP_DECJ_A,
            `LBE_OP_DECJ_B:  cycles_of = `LBE_CYC_DECJ;
            `LBE_OP_DSUB_BA: cycles_of = `LBE_CYC_DSUB_BA;
            `LBE_OP_DSUB_RA: cycles_of = `LBE_CYC_DSUB_RA;
            `LBE_OP_DSUB_RB: cycles_of = `LBE_CYC_DSUB_RB;
            `LBE_OP_DSUB_RR: cycles_of = `LBE_CYC_DSUB_RR;
            `LBE_OP_DSUB_IA: cycles_of = `LBE_CYC_DSUB_IA;
            `LBE_OP_DSUB_IB: cycles_of = `LBE_CYC_DSUB_IB;
            `LBE_OP_DSUB_IR: cycles_of = `LBE_CYC_DSUB_IR;
            default:         cycles_of = `LBE_CYC_ENALL;
        endcase
    endfunction

    assign kind   = kind_of(instr_ff[7:0], instr_ff[15:8]);
    assign cycles = cycles_of(instr_ff[7:0]);
    assign idle   = (state_ff == ph_idle);
    assign commit = (state_ff == ph_exec) && (cnt_ff == 4'd1);
    assign sp_up  = sp_ff[3:0] + 4'd1;

    // operand routing: A is file entry 0, B is entry 1
    always_comb begin
        d_idx = 4'd0;
        s_val = rf_ff[instr_ff[19:16]];
        case (instr_ff[7:0])
            `LBE_OP_DECJ_B,
            `LBE_OP_DSUB_RB: d_idx = 4'd1;
            `LBE_OP_DSUB_BA: s_val = rf_ff[1];
            `LBE_OP_DSUB_RR: d_idx = instr_ff[27:24];
            `LBE_OP_DSUB_IA: s_val = instr_ff[23:16];
            `LBE_OP_DSUB_IB: begin
                d_idx = 4'd1;
                s_val = instr_ff[23:16];
            end
            `LBE_OP_DSUB_IR: begin
                d_idx = instr_ff[27:24];
                s_val = instr_ff[23:16];
            end
            default: d_idx = 4'd0;
        endcase
    end

    assign d_val  = rf_ff[d_idx];
    assign dj_val = d_val - 8'h01;

    // immediate zero with carry set yields the destination itself
    lbe_bcd_sub u_bcd (
        .dst       (d_val),
        .src       (s_val),
        .carry_in  (flags_ff[`LBE_FLG_C]),
        .result    (bcd_res),
        .carry_out (bcd_c)
    );

    // ======================================================================
    // ahb-lite slave: zero wait states, always okay
    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_go   = wr_pend_ff && idle;

    function automatic logic [31:0] rd_mux(input logic [11:0] a);
        if (a == `LBE_OFF_INSTR) begin
            return instr_ff;
        end else if (a == `LBE_OFF_PC) begin
            return {16'h0000, pc_ff};
        end else if (a == `LBE_OFF_FLAGS) begin
            return {24'h00_0000, flags_ff};
        end else if (a == `LBE_OFF_STATUS) begin
            return {30'h0000_0000, bad_ff, ~idle};
        end else if (a == `LBE_OFF_SP) begin
            return {24'h00_0000, sp_ff};
        end else if (a >= `LBE_OFF_RF_BASE && a <= `LBE_OFF_RF_LAST) begin
            return {24'h00_0000, rf_ff[a[5:2]]};
        end else begin
            return 32'h0000_0000;
        end
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h000;
        end else begin
            wr_pend_ff <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_addr_ff <= {haddr[11:2], 2'b00};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_ff <= rd_mux({haddr[11:2], 2'b00});
        end
    end

    assign hrdata    = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ======================================================================
    // sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= ph_idle;
            cnt_ff   <= 4'd0;
        end else begin
            case (state_ff)
                ph_idle: begin
                    if (wr_go && wr_addr_ff == `LBE_OFF_CMD) begin
                        case (lbe_cmd_e'(hwdata[1:0]))
                            cmd_exec: begin
                                if (kind != k_bad) begin
                                    state_ff <= ph_exec;
                                    cnt_ff   <= cycles;
                                end
                            end
                            cmd_irq_entry: state_ff <= ph_irq_push;
                            default:       state_ff <= ph_pop;
                        endcase
                    end
                end
                ph_exec: begin
                    cnt_ff <= cnt_ff - 4'd1;
                    if (cnt_ff == 4'd1) begin
                        state_ff <= ph_idle;
                    end
                end
                ph_irq_push: state_ff <= ph_irq_mask;
                default:     state_ff <= ph_idle;
            endcase
        end
    end

    // bad opcode: sticky, write one to clear, a new fault wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bad_ff <= 1'b0;
        end else if (wr_go && wr_addr_ff == `LBE_OFF_CMD &&
                     hwdata[1:0] == 2'b00 && kind == k_bad) begin
            bad_ff <= 1'b1;
        end else if (wr_go && wr_addr_ff == `LBE_OFF_STATUS &&
                     hwdata[`LBE_STS_BAD]) begin
            bad_ff <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_ff <= 32'h0000_0000;
        end else if (wr_go && wr_addr_ff == `LBE_OFF_INSTR) begin
            instr_ff <= hwdata;
        end
    end

    // pc holds the next-instruction address of the loaded instruction
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_ff <= 16'h0000;
        end else if (commit && kind == k_decj && dj_val != 8'h00) begin
            pc_ff <= pc_ff + {{8{instr_ff[31]}}, instr_ff[31:24]};
        end else if (wr_go && wr_addr_ff == `LBE_OFF_PC) begin
            pc_ff <= hwdata[15:0];
        end
    end

    // decrement-jump has no arm here, so it never touches the flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_ff <= `LBE_FLAGS_RST;
        end else if (commit && kind == k_dsub) begin
            flags_ff[`LBE_FLG_C] <= bcd_c;
            flags_ff[`LBE_FLG_N] <= bcd_res[7];
            flags_ff[`LBE_FLG_Z] <= (bcd_res == 8'h00);
        end else if (commit && kind == k_enall) begin
            flags_ff <= `LBE_ENALL_VALUE;
        end else if (state_ff == ph_irq_mask) begin
            flags_ff <= flags_ff & ~(`LBE_IEH_MASK | `LBE_IEL_MASK);
        end else if (state_ff == ph_pop) begin
            flags_ff <= rf_ff[sp_ff[3:0]];
        end else if (wr_go && wr_addr_ff == `LBE_OFF_FLAGS) begin
            flags_ff <= hwdata[7:0];
        end
    end

    assign high_level_irq_enable = flags_ff[`LBE_FLG_IEH];
    assign low_level_irq_enable  = flags_ff[`LBE_FLG_IEL];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_ff <= 8'h00;
        end else if (state_ff == ph_irq_push) begin
            sp_ff <= sp_ff + 8'h01;
        end else if (state_ff == ph_pop) begin
            sp_ff <= sp_ff - 8'h01;
        end else if (wr_go && wr_addr_ff == `LBE_OFF_SP) begin
            sp_ff <= hwdata[7:0];
        end
    end

    // ======================================================================
    // register file, stack shares it
    always_comb begin
        rf_we = 1'b0;
        rf_wa = d_idx;
        rf_wd = bcd_res;
        if (commit && kind == k_decj) begin
            rf_we = 1'b1;
            rf_wd = dj_val;
        end else if (commit && kind == k_dsub) begin
            rf_we = 1'b1;
        end else if (state_ff == ph_irq_push) begin
            rf_we = 1'b1;
            rf_wa = sp_up;
            rf_wd = flags_ff;
        end else if (wr_go && wr_addr_ff >= `LBE_OFF_RF_BASE &&
                     wr_addr_ff <= `LBE_OFF_RF_LAST) begin
            rf_we = 1'b1;
            rf_wa = wr_addr_ff[5:2];
            rf_wd = hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `LBE_RF_DEPTH; i++) begin
                rf_ff[i] <= 8'h00;
            end
        end else if (rf_we) begin
            rf_ff[rf_wa] <= rf_wd;
        end
    end
endmodule // lbe_exec
`default_nettype wire

// ---- verif/lbe_exec_chk.sv ----
// assertions on the execution block's bus and enable pins
`timescale 1ns/100ps
`default_nettype none
`include "lbe_regs.svh"
module lbe_exec_chk
    import lbe_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        high_level_irq_enable,
    input wire logic        low_level_irq_enable
);
    // =====================================================================
    // data-phase tracking
    logic        dp_ff;
    logic        dw_ff;
    logic [11:0] da_ff;
    logic [15:0] op_ff;
    wire logic   hi = high_level_irq_enable;
    wire logic   lo = low_level_irq_enable;
    wire logic   wr = dp_ff && dw_ff;
    wire logic   rd = dp_ff && !dw_ff;
    wire logic   cmd = wr && da_ff == `LBE_OFF_CMD;
    wire logic   ex = cmd && hwdata[1:0] == 2'd0;
    wire logic   all_go = ex && op_ff == {`LBE_OP_ENALL2, `LBE_OP_EXT};
    wire logic   dj_go = ex && (op_ff[7:0] == `LBE_OP_DECJ_A
                                || op_ff[7:0] == `LBE_OP_DECJ_B);
    wire logic   irq_go = cmd && hwdata[1:0] == 2'd1;
    wire logic   fl_wr = wr && da_ff == `LBE_OFF_FLAGS;
    wire logic   fl_rd = rd && da_ff == `LBE_OFF_FLAGS;
    wire logic   mapped = da_ff[11:2] <= 10'd5 || da_ff[11:6] == 6'h04;
    wire logic   zero_rd = rd && (da_ff == `LBE_OFF_CMD || !mapped);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_ff <= 1'b0;
            dw_ff <= 1'b0;
            da_ff <= 12'h000;
            op_ff <= 16'h0000;
        end else begin
            dp_ff <= hsel && htrans[1] && hready;
            dw_ff <= hwrite;
            da_ff <= haddr[11:0];
            if (wr && da_ff == `LBE_OFF_INSTR) begin
                op_ff <= hwdata[15:0];
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence en_held;
        $stable({hi, lo});
    endsequence

    ready_high_a: assert property (hreadyout == 1'b1)
        else $error("wait state inserted");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("error response given");
    zero_read_a: assert property (zero_rd |-> hrdata == 32'h0000_0000)
        else $error("command or unmapped read not zero");
    flags_wr_a: assert property (fl_wr |=> hi == $past(hwdata[2]) && lo == $past(hwdata[3]))
        else $error("enable pins do not follow flags write");
    flags_rd_a: assert property (fl_rd |-> hrdata[2] == hi && hrdata[3] == lo)
        else $error("enable pins differ from flags read");
    enall_time_a: assert property (all_go |-> en_held [*7] ##1 (hi && lo))
        else $error("enable-all not applied after six cycles");
    irq_clear_a: assert property (irq_go |-> ##1 en_held ##1 en_held ##1 (!hi && !lo))
        else $error("enables not cleared after push");
    decrement_jump_nonzero_keep_a: assert property (dj_go |=> en_held [*8])
        else $error("decrement-jump changed enables");
endmodule // lbe_exec_chk

bind lbe_exec lbe_exec_chk chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .high_level_irq_enable(high_level_irq_enable),
    .low_level_irq_enable(low_level_irq_enable)
);
`default_nettype wire

// ---- verif/lbe_exec_tb_top.sv ----
// self-checking bench for the execution block
`timescale 1ns/100ps
`default_nettype none
`include "lbe_regs.svh"
module lbe_exec_tb_top
    import lbe_pkg::*;
;
    // =====================================================================
    // bench signals
    logic        hclk, hresetn, hsel, hwrite, rd_ph, c;
    logic        high_level_irq_enable, low_level_irq_enable, hreadyout, hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    wire logic   hready;
    logic [31:0] exp_q[$];
    logic [7:0]  rv[10], op, v, off, fl, s;
    logic [15:0] pc;
    logic [8:0]  res;
    int          n_fail, compares, seed, k, i, j, dx;
    logic [7:0]  sub_ops[7] = '{`LBE_OP_DSUB_BA, `LBE_OP_DSUB_RA,
        `LBE_OP_DSUB_RB, `LBE_OP_DSUB_RR, `LBE_OP_DSUB_IA, `LBE_OP_DSUB_IB,
        `LBE_OP_DSUB_IR};
    int          dx_t[7] = '{0, 0, 1, 9, 0, 1, 9};

    assign hready = hreadyout;

    lbe_exec dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .high_level_irq_enable(high_level_irq_enable),
        .low_level_irq_enable(low_level_irq_enable)
    );

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("mismatches %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1) begin
            n_fail++;
            results();
        end
    endtask

    // one single transfer; read data lands in q
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {20'h0_0000, a};
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, $random(seed));
    endtask

    // writes are dropped while busy, so always poll to idle
    task automatic run(input logic [1:0] cm);
        int n;
        wr(`LBE_OFF_CMD, {30'h0000_0000, cm});
        n = 0;
        do begin
            bus(1'b0, `LBE_OFF_STATUS, 32'h0000_0000);
            n++;
        end while (q[0] !== 1'b0 && n < 20);
        if (q[0] !== 1'b0) begin
            n_fail++;
            results();
        end
    endtask

    function automatic logic [11:0] rfa(input int x);
        return `LBE_OFF_RF_BASE + 12'(4 * x);
    endfunction

    function automatic logic [7:0] rbcd();
        int r;
        r = {$random(seed)} % 100;
        return {4'(r / 10), 4'(r % 10)};
    endfunction

    function automatic logic [8:0] bcd_sub(input logic [7:0] d, s,
                                            input logic ci);
        int r;
        r = d[7:4] * 10 + d[3:0] - s[7:4] * 10 - s[3:0] - 1 + ci;
        if (r < 0) begin
            r = r + 100;
            return {1'b0, 4'(r / 10), 4'(r % 10)};
        end
        return {1'b1, 4'(r / 10), 4'(r % 10)};
    endfunction

    // look mid data phase: at the edge the next expectation may race in
    always @(negedge hclk) begin
        if (rd_ph && exp_q.size() > 0) begin
            check(hrdata, exp_q.pop_front());
        end
    end

    always @(posedge hclk) begin
        rd_ph <= hresetn && hsel && htrans[1] && hready && !hwrite;
    end

    initial begin
        seed = 32'h0000_69b3;
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        n_fail = 0;
        compares = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`LBE_OFF_FLAGS, 32'h0000_0000);
        rd(`LBE_OFF_CMD, 32'h0000_0000);
        rd(12'h020, 32'h0000_0000);
        for (k = 0; k < 6; k++) begin
            op = k[0] ? `LBE_OP_DECJ_B : `LBE_OP_DECJ_A;
            v = (k < 2) ? 8'h01 : (k < 4) ? 8'h00 : 8'($random(seed));
            off = 8'($random(seed));
            fl = 8'($random(seed));
            pc = 16'($random(seed));
            wr(`LBE_OFF_INSTR, {off, 16'h0000, op});
            wr(`LBE_OFF_PC, {16'h0000, pc});
            wr(`LBE_OFF_FLAGS, {24'h00_0000, fl});
            wr(rfa(k % 2), {24'h00_0000, v});
            run(2'd0);
            v = v - 8'h01;
            if (v != 8'h00) pc = pc + {{8{off[7]}}, off};
            rd(rfa(k % 2), {24'h00_0000, v});
            rd(`LBE_OFF_PC, {16'h0000, pc});
            rd(`LBE_OFF_FLAGS, {24'h00_0000, fl});
        end
        // first pass gives the three immediate forms zero: conditional decrement
        for (k = 0; k < 14; k++) begin
            j = k % 7;
            dx = dx_t[j];
            s = (k < 7) ? 8'h00 : rbcd();
            c = 1'($random(seed));
            fl = {c, 7'($random(seed))};
            for (i = 0; i < 10; i++) begin
                rv[i] = rbcd();
                wr(rfa(i), {24'h00_0000, rv[i]});
            end
            wr(`LBE_OFF_FLAGS, {24'h00_0000, fl});
            wr(`LBE_OFF_INSTR, {8'h09, j < 4 ? 8'h05 : s, 8'h00, sub_ops[j]});
            run(2'd0);
            if (j < 4) s = (j == 0) ? rv[1] : rv[5];
            res = bcd_sub(rv[dx], s, c);
            rd(rfa(dx), {24'h00_0000, res[7:0]});
            rd(`LBE_OFF_FLAGS, {24'h00_0000, res[8], res[7],
                res[7:0] == 8'h00, fl[4:0]});
        end
        wr(`LBE_OFF_FLAGS, {24'h00_0000, 8'($random(seed)) & 8'hF3});
        wr(`LBE_OFF_INSTR, {16'h0000, `LBE_OP_ENALL2, `LBE_OP_EXT});
        run(2'd0);
        rd(`LBE_OFF_FLAGS, 32'h0000_000C);
        wr(`LBE_OFF_FLAGS, 32'h0000_008C);
        wr(`LBE_OFF_SP, 32'h0000_0003);
        run(2'd1);
        rd(rfa(4), 32'h0000_008C);
        rd(`LBE_OFF_FLAGS, 32'h0000_0080);
        rd(`LBE_OFF_SP, 32'h0000_0004);
        run(2'd2);
        rd(`LBE_OFF_FLAGS, 32'h0000_008C);
        wr(rfa(3), 32'h0000_0040);
        run(2'd3);
        rd(`LBE_OFF_FLAGS, 32'h0000_0040);
        rd(`LBE_OFF_SP, 32'h0000_0002);
        repeat (2) @(posedge hclk);
        results();
    end
endmodule // lbe_exec_tb_top
`default_nettype wire
